/* File: design/utp_regs.vh */
// Register map, field positions and reset values of the test-pattern block
`ifndef UTP_REGS_VH
`define UTP_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define UTP_TX_LENGTH_LOW_OFS 16'h1000
`define UTP_TX_LENGTH_HIGH_OFS 16'h1004
`define UTP_TEST_COMMAND_OFS 16'h1008
`define UTP_LOGIC_RESET_OFS 16'h100C
`define UTP_FIFO_STATUS_OFS 16'h1010
`define UTP_RX_LENGTH_LOW_OFS 16'h1014
`define UTP_RX_LENGTH_HIGH_OFS 16'h1018

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UTP_CMD_START_BIT 0
`define UTP_CMD_VERIFY_BIT 1
`define UTP_RST_LOGIC_BIT 0
`define UTP_RST_TIMEOUT_BIT 8
`define UTP_RST_LINK_BIT 16
`define UTP_FFS_TXFULL_BIT 24
`define UTP_LEN_HIGH_BITS 11

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UTP_LEN_RESET 43'h000_0000_0000
`define UTP_WORD_RESET 32'h0000_0000

`endif

/* File: design/utp_user_register_block.v */
// Test-pattern register block, pattern generator and pattern verifier
`timescale 1ns/1ps
`default_nettype none
`include "utp_regs.vh"

module utp_user_register_block #(
  parameter LEN_W = 43,
  parameter DATA_W = 256,
  parameter ADDR_W = 14
) (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // Register port, address in 32-bit words
  input wire reg_wr_en,
  input wire [ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wr_data,
  input wire [3:0] reg_write_byte_mask,
  input wire reg_rd_req,
  output reg [31:0] reg_rd_data,
  output reg reg_read_valid,
  // Core transmit FIFO
  output wire core_tx_fifo_write,
  output wire [DATA_W-1:0] core_tx_fifo_wdata,
  input wire core_tx_fifo_full,
  // Core receive FIFO
  output wire core_rx_fifo_read,
  input wire [DATA_W-1:0] core_rx_fifo_rdata,
  input wire core_rx_fifo_empty,
  input wire [4:0] rx_last_word_bytes,
  input wire [10:0] rx_fifo_word_count,
  // Core status
  input wire core_timeout_irq,
  input wire link_up
);

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n;

  // Release is synchronised so all flops leave reset on one edge
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  wire [15:0] byte_addr;
  wire sel_txl;
  wire sel_txh;
  wire sel_cmd;
  wire sel_rst;
  wire wr_cmd;
  wire wr_rst;

  // Byte mask unused: every write is a full word
  assign byte_addr = {reg_addr, 2'b00};
  assign sel_txl = (byte_addr == `UTP_TX_LENGTH_LOW_OFS);
  assign sel_txh = (byte_addr == `UTP_TX_LENGTH_HIGH_OFS);
  assign sel_cmd = (byte_addr == `UTP_TEST_COMMAND_OFS);
  assign sel_rst = (byte_addr == `UTP_LOGIC_RESET_OFS);
  assign wr_cmd = reg_wr_en & sel_cmd;
  assign wr_rst = reg_wr_en & sel_rst;

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  reg [LEN_W-1:0] programmed_tx_total;
  reg verify_enable;
  reg logic_reset_q;
  reg timeout_latch_q;

  // Total length, verify mode, self-clearing logic reset
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      programmed_tx_total <= `UTP_LEN_RESET;
      verify_enable <= 1'b0;
      logic_reset_q <= 1'b0;
    end
    else
    begin
      if (reg_wr_en && sel_txl)
        programmed_tx_total[31:0] <= reg_wr_data;
      if (reg_wr_en && sel_txh)
        programmed_tx_total[LEN_W-1:32] <= reg_wr_data[10:0];
      if (wr_cmd)
        verify_enable <= reg_wr_data[`UTP_CMD_VERIFY_BIT];
      // Pulse lasts one cycle, so the bit reads back as zero
      logic_reset_q <= wr_rst & reg_wr_data[`UTP_RST_LOGIC_BIT];
    end
  end

  // Timeout latch; a new interrupt beats a same-cycle clear
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      timeout_latch_q <= 1'b0;
    else if (core_timeout_irq)
      timeout_latch_q <= 1'b1;
    else if (wr_rst && reg_wr_data[`UTP_RST_TIMEOUT_BIT])
      timeout_latch_q <= 1'b0;
  end

  // --------------------------------------------------------------------
  // Pattern generator
  // --------------------------------------------------------------------
  reg tx_transfer_enable;
  reg [LEN_W-1:0] sent_word_counter;
  wire tx_fire;
  wire [LEN_W-1:0] sent_next;

  assign tx_fire = tx_transfer_enable & ~core_tx_fifo_full;
  assign core_tx_fifo_write = tx_fire;
  assign sent_next = sent_word_counter + {{(LEN_W-1){1'b0}}, 1'b1};

  // Counter doubles as the pattern source for the data bus
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_transfer_enable <= 1'b0;
      sent_word_counter <= `UTP_LEN_RESET;
    end
    else if (logic_reset_q)
    begin
      tx_transfer_enable <= 1'b0;
      sent_word_counter <= `UTP_LEN_RESET;
    end
    else if (wr_cmd)
    begin
      // Zero total would never terminate, so it does not start
      tx_transfer_enable <= reg_wr_data[`UTP_CMD_START_BIT] &
        (programmed_tx_total != `UTP_LEN_RESET);
      sent_word_counter <= `UTP_LEN_RESET;
    end
    else if (tx_fire)
    begin
      sent_word_counter <= sent_next;
      if (sent_next == programmed_tx_total)
        tx_transfer_enable <= 1'b0;
    end
  end

  // Eight incrementing 32-bit lanes per 256-bit word
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W/32; gi = gi + 1)
    begin : g_tx_lane
      // Lane number kept as a sized constant; only its low bits are used
      localparam [31:0] LANE_NUM = gi;
      wire [2:0] lane_idx = LANE_NUM[2:0];
      assign core_tx_fifo_wdata[gi*32 +: 32] =
        {sent_word_counter[28:0], lane_idx};
    end
  endgenerate

  // --------------------------------------------------------------------
  // Pattern verifier
  // --------------------------------------------------------------------
  reg rx_read_delayed;
  reg [LEN_W-1:0] received_word_counter;
  reg verify_fail_flag;
  wire [DATA_W-1:0] expected_pattern;
  wire mismatch;

  // Drain whenever data is present; no stall from this side
  assign core_rx_fifo_read = ~core_rx_fifo_empty;

  generate
    for (gi = 0; gi < DATA_W/32; gi = gi + 1)
    begin : g_rx_lane
      localparam [31:0] LANE_NUM = gi;
      wire [2:0] lane_idx = LANE_NUM[2:0];
      assign expected_pattern[gi*32 +: 32] =
        {received_word_counter[28:0], lane_idx};
    end
  endgenerate

  assign mismatch = rx_read_delayed & verify_enable &
    (core_rx_fifo_rdata != expected_pattern);

  // Data is valid the cycle after the read strobe
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_read_delayed <= 1'b0;
      received_word_counter <= `UTP_LEN_RESET;
      verify_fail_flag <= 1'b0;
    end
    else
    begin
      rx_read_delayed <= core_rx_fifo_read;
      if (logic_reset_q)
        received_word_counter <= `UTP_LEN_RESET;
      else if (wr_cmd)
        received_word_counter <= `UTP_LEN_RESET;
      else if (rx_read_delayed)
        received_word_counter <= received_word_counter +
          {{(LEN_W-1){1'b0}}, 1'b1};
      // A mismatch in the clearing cycle still lands
      if (mismatch)
        verify_fail_flag <= 1'b1;
      else if (logic_reset_q || wr_cmd)
        verify_fail_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  reg [31:0] rd_mux;

  // Unmapped addresses read as zero
  always @*
  begin
    rd_mux = `UTP_WORD_RESET;
    case (byte_addr)
      `UTP_TX_LENGTH_LOW_OFS: rd_mux = sent_word_counter[31:0];
      `UTP_TX_LENGTH_HIGH_OFS:
        rd_mux[10:0] = sent_word_counter[LEN_W-1:32];
      `UTP_TEST_COMMAND_OFS:
      begin
        rd_mux[`UTP_CMD_START_BIT] = tx_transfer_enable;
        rd_mux[`UTP_CMD_VERIFY_BIT] = verify_fail_flag;
      end
      `UTP_LOGIC_RESET_OFS:
      begin
        rd_mux[`UTP_RST_TIMEOUT_BIT] = timeout_latch_q;
        rd_mux[`UTP_RST_LINK_BIT] = link_up;
      end
      `UTP_FIFO_STATUS_OFS:
      begin
        rd_mux[4:0] = rx_last_word_bytes;
        rd_mux[15:5] = rx_fifo_word_count;
        rd_mux[`UTP_FFS_TXFULL_BIT] = core_tx_fifo_full;
      end
      `UTP_RX_LENGTH_LOW_OFS:
        rd_mux = received_word_counter[31:0];
      `UTP_RX_LENGTH_HIGH_OFS:
        rd_mux[10:0] = received_word_counter[LEN_W-1:32];
      default: rd_mux = `UTP_WORD_RESET;
    endcase
  end

  // One flop of latency for data and valid alike
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rd_data <= `UTP_WORD_RESET;
      reg_read_valid <= 1'b0;
    end
    else
    begin
      reg_read_valid <= reg_rd_req;
      if (reg_rd_req)
        reg_rd_data <= rd_mux;
    end
  end

endmodule // utp_user_register_block

`default_nettype wire

/* File: verification/utp_user_register_block_assertions.sv */
// Port checker for the test-pattern register block
`timescale 1ns/1ps
`default_nettype none
module utp_chk #(
  parameter LEN_W = 43,
  parameter DATA_W = 256,
  parameter ADDR_W = 14
) (
  // Clock, reset and register port
  input wire logic mclk,
  input wire logic resetn,
  input wire logic reg_wr_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_rd_req,
  input wire logic [31:0] reg_rd_data,
  input wire logic reg_read_valid,
  // Core FIFO side
  input wire logic core_tx_fifo_write,
  input wire logic [DATA_W-1:0] core_tx_fifo_wdata,
  input wire logic core_tx_fifo_full,
  input wire logic core_rx_fifo_read,
  input wire logic core_rx_fifo_empty
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // Programmed total and words written since the last restart
  logic [LEN_W-1:0] tot_q, cnt_q;
  logic srst_q;
  wire cmd_w = reg_wr_en && reg_addr == 'h402;
  // Soft reset clears a cycle late, so the clear is delayed to match
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      tot_q <= '0;
      cnt_q <= '0;
      srst_q <= 1'b0;
    end
    else
    begin
      srst_q <= reg_wr_en && reg_addr == 'h403 && reg_wr_data[0];
      if (reg_wr_en && reg_addr == 'h400)
        tot_q[31:0] <= reg_wr_data;
      if (reg_wr_en && reg_addr == 'h401)
        tot_q[LEN_W-1:32] <= reg_wr_data[10:0];
      if (cmd_w || srst_q)
        cnt_q <= '0;
      else if (core_tx_fifo_write)
        cnt_q <= cnt_q + 1'b1;
    end
  sequence s_two_wr;
    core_tx_fifo_write ##1 core_tx_fifo_write;
  endsequence
  AST_RD_VALID: assert property (reg_rd_req |=> reg_read_valid)
    else $error("read valid missing");
  AST_RD_ONLY: assert property (reg_read_valid |-> $past(reg_rd_req))
    else $error("read valid without request");
  AST_RD_HOLD: assert property (!reg_read_valid |-> $stable(reg_rd_data))
    else $error("read data moved");
  AST_RX_READ: assert property (core_rx_fifo_read == !core_rx_fifo_empty)
    else $error("rx read not inverse of empty");
  AST_NO_WR_FULL: assert property (core_tx_fifo_full |-> !core_tx_fifo_write)
    else $error("tx write while full");
  AST_LANES: assert property (core_tx_fifo_write |->
    core_tx_fifo_wdata[63:32] == core_tx_fifo_wdata[31:0] + 32'h1 &&
    core_tx_fifo_wdata[255:224] == core_tx_fifo_wdata[31:0] + 32'h7)
    else $error("lane pattern wrong");
  AST_PATT_STEP: assert property (s_two_wr |-> $past(reg_wr_en) ||
    core_tx_fifo_wdata[31:0] == $past(core_tx_fifo_wdata[31:0]) + 32'h8)
    else $error("pattern did not step");
  AST_TX_LIMIT: assert property (core_tx_fifo_write |-> cnt_q < tot_q)
    else $error("write beyond programmed total");
endmodule // utp_chk
bind utp_user_register_block utp_chk #(
  .LEN_W(LEN_W), .DATA_W(DATA_W), .ADDR_W(ADDR_W)
) utp_chk_inst (
  .mclk, .resetn, .reg_wr_en, .reg_addr, .reg_wr_data, .reg_rd_req,
  .reg_rd_data, .reg_read_valid, .core_tx_fifo_write, .core_tx_fifo_wdata,
  .core_tx_fifo_full, .core_rx_fifo_read, .core_rx_fifo_empty
);
`default_nettype wire

/* File: verification/utp_core_model.sv */
// Behavioural model of the offload core FIFO side
`timescale 1ns/1ps
`default_nettype none
module utp_core_model (
  // Clock and stall control
  input wire logic mclk,
  input wire logic stall,
  // Transmit FIFO
  input wire logic core_tx_fifo_write,
  input wire logic [255:0] core_tx_fifo_wdata,
  output logic core_tx_fifo_full,
  // Receive FIFO
  input wire logic core_rx_fifo_read,
  output logic core_rx_fifo_empty,
  output logic [255:0] core_rx_fifo_rdata
);
  int rx_left = 0;
  int rx_n = 0;
  int bad_n = -1;
  int tx_n = 0;
  logic [31:0] first_w = 32'hffff_ffff;
  assign core_tx_fifo_full = stall;
  assign core_rx_fifo_empty = rx_left == 0;
  initial core_rx_fifo_rdata = '0;
  // Data valid the cycle after a read; otherwise the bus is scrambled
  always @(posedge mclk)
  begin
    if (core_tx_fifo_write && tx_n == 0)
      first_w <= core_tx_fifo_wdata[31:0];
    if (core_tx_fifo_write)
      tx_n <= tx_n + 1;
    if (core_rx_fifo_read && rx_left > 0)
    begin
      for (int i = 0; i < 8; i++)
        core_rx_fifo_rdata[32*i+:32] <= {rx_n[28:0], i[2:0]} ^ (rx_n == bad_n);
      rx_n <= rx_n + 1;
      rx_left <= rx_left - 1;
    end
    else
      core_rx_fifo_rdata <= ~core_rx_fifo_rdata;
  end
endmodule // utp_core_model
`default_nettype wire

/* File: verification/tb_utp_user_register_block.sv */
// Self-checking bench for the test-pattern register block
`timescale 1ns/1ps
`default_nettype none
module tb_utp_user_register_block;
  logic mclk = 0, resetn = 0, reg_wr_en = 0, reg_rd_req = 0, stall = 0;
  logic core_timeout_irq = 0, link_up = 1, reg_read_valid;
  logic [13:0] reg_addr = '0;
  logic [31:0] reg_wr_data = '0, reg_rd_data;
  logic [3:0] reg_write_byte_mask = 4'h0;
  logic [4:0] rx_last_word_bytes = 5'h15;
  logic [10:0] rx_fifo_word_count = 11'h5a3;
  wire core_tx_fifo_write, core_tx_fifo_full, core_rx_fifo_read;
  wire core_rx_fifo_empty;
  wire [255:0] core_tx_fifo_wdata, core_rx_fifo_rdata;
  int n_fail = 0, checks_done = 0;
  always #2 mclk = ~mclk;
  utp_user_register_block utp_user_register_block_inst (.mclk, .resetn,
    .reg_wr_en, .reg_addr, .reg_wr_data, .reg_write_byte_mask, .reg_rd_req,
    .reg_rd_data, .reg_read_valid, .core_tx_fifo_write, .core_tx_fifo_wdata,
    .core_tx_fifo_full, .core_rx_fifo_read, .core_rx_fifo_rdata,
    .core_rx_fifo_empty, .rx_last_word_bytes, .rx_fifo_word_count,
    .core_timeout_irq, .link_up);
  utp_core_model utp_core_model_inst (.mclk, .stall, .core_tx_fifo_write,
    .core_tx_fifo_wdata, .core_tx_fifo_full, .core_rx_fifo_read,
    .core_rx_fifo_empty, .core_rx_fifo_rdata);
  // ------
  // Bus tasks; byte mask left at zero since it must be ignored
  // ------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk) #1;
    reg_wr_en = 1;
    reg_addr = a[15:2];
    reg_wr_data = d;
    @(posedge mclk) #1;
    reg_wr_en = 0;
  endtask
  task cr(input logic [15:0] a, input logic [31:0] e);
    @(posedge mclk) #1;
    reg_rd_req = 1;
    reg_addr = a[15:2];
    @(posedge mclk) #1;
    reg_rd_req = 0;
    chk(reg_read_valid, 1);
    chk(reg_rd_data, e);
  endtask
  task wait_idle;
    repeat (100)
    begin
      @(posedge mclk) #1;
      if (utp_core_model_inst.tx_n >= 5)
        break;
    end
    repeat (4) @(posedge mclk);
    cr(16'h1008, 0);
  endtask
  // ------
  // Scenarios
  // ------
  task t_status;
    stall = 1;
    cr(16'h1010, 32'h0100_b475);
    stall = 0;
    cr(16'h1014, 0);
    link_up = 0;
    cr(16'h100c, 0);
    link_up = 1;
    cr(16'h100c, 32'h0001_0000);
    cr(16'h1030, 0);
    $display("status test done");
  endtask
  task t_tx;
    wr(16'h1000, 5);
    wr(16'h1004, 0);
    stall = 1;
    wr(16'h1008, 1);
    cr(16'h1008, 1);
    chk(utp_core_model_inst.tx_n, 0);
    stall = 0;
    wait_idle;
    chk(utp_core_model_inst.tx_n, 5);
    chk(utp_core_model_inst.first_w, 0);
    cr(16'h1000, 5);
    cr(16'h1004, 0);
    $display("tx test done");
  endtask
  task t_rx;
    wr(16'h1008, 2);
    cr(16'h1000, 0);
    utp_core_model_inst.rx_left = 6;
    repeat (10) @(posedge mclk);
    cr(16'h1014, 6);
    cr(16'h1018, 0);
    cr(16'h1008, 0);
    utp_core_model_inst.rx_n = 0;
    utp_core_model_inst.bad_n = 2;
    wr(16'h1008, 2);
    utp_core_model_inst.rx_left = 4;
    repeat (8) @(posedge mclk);
    cr(16'h1008, 2);
    utp_core_model_inst.rx_n = 0;
    wr(16'h1008, 0);
    cr(16'h1008, 0);
    utp_core_model_inst.rx_left = 4;
    repeat (8) @(posedge mclk);
    cr(16'h1008, 0);
    cr(16'h1014, 4);
    $display("rx test done");
  endtask
  task t_high;
    wr(16'h1000, 0);
    wr(16'h1004, 32'hffff_f801);
    wr(16'h1008, 1);
    cr(16'h1008, 1);
    utp_core_model_inst.rx_left = 3;
    repeat (6) @(posedge mclk);
    cr(16'h1014, 3);
    wr(16'h100c, 1);
    cr(16'h100c, 32'h0001_0000);
    cr(16'h1008, 0);
    cr(16'h1000, 0);
    cr(16'h1014, 0);
    $display("soft reset test done");
  endtask
  task t_irq;
    core_timeout_irq = 1;
    @(posedge mclk) #1;
    core_timeout_irq = 0;
    cr(16'h100c, 32'h0001_0100);
    cr(16'h100c, 32'h0001_0100);
    wr(16'h100c, 32'h0000_0100);
    cr(16'h100c, 32'h0001_0000);
    $display("timeout test done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence; internal reset needs two edges after release
  initial
  begin
    repeat (5) @(posedge mclk);
    #1 resetn = 1;
    repeat (3) @(posedge mclk);
    #1;
    // Link must be reported up before any test starts
    cr(16'h100c, 32'h0001_0000);
    t_status;
    t_tx;
    t_rx;
    t_high;
    t_irq;
    wrap_up;
  end
  // Watchdog well beyond the hundred-odd cycles the tests need
  initial
  begin
    #20000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up;
  end
endmodule // tb_utp_user_register_block
`default_nettype wire
